//--- shared/tsfo_cfg.svh
// register map, field positions, reset values and timing counts of the tdm frame output
`ifndef TSFO_CFG_SVH
`define TSFO_CFG_SVH
`define TSFO_OFF_CTRL 12'h000
`define TSFO_OFF_FSW 12'h004
`define TSFO_OFF_FLEN 12'h008
`define TSFO_OFF_SLOT_LO 12'h00C
`define TSFO_OFF_SLOT_HI 12'h010
`define TSFO_OFF_STATUS 12'h014
`define TSFO_CTRL_EN 0
`define TSFO_CTRL_MASTER 1
`define TSFO_CTRL_INVERT 2
`define TSFO_CTRL_EARLY 3
`define TSFO_CTRL_HALF_DUTY 4
`define TSFO_CTRL_HIGH_REF 5
`define TSFO_FSW_MSB 10
`define TSFO_FSW_UPPER_LSB 3
`define TSFO_FLEN_MSB 15
`define TSFO_SLOT_HI_MSB 15
`define TSFO_ST_UNDERRUN 0
`define TSFO_ST_RATE_ERR 1
`define TSFO_ST_ACTIVE 2
`define TSFO_ST_SLOTS_LSB 8
`define TSFO_RST_CTRL 6'h00
`define TSFO_RST_FSW 11'h000
`define TSFO_RST_FLEN 16'h0190
`define TSFO_RST_SLOT 48'h0000_0000_0000
`define TSFO_MAX_SLOTS 48
`define TSFO_SLOT_BITS 8
`define TSFO_MCLK_KHZ 25000
`define TSFO_BCLK_MAX_KHZ 6400
`define TSFO_BCLK_MIN_HALF_CYC \
  ((`TSFO_MCLK_KHZ + 2 * `TSFO_BCLK_MAX_KHZ - 1) / (2 * `TSFO_BCLK_MAX_KHZ))
`endif

//--- shared/tsfo_pkg.sv
// types shared by the tdm frame output design
`default_nettype none
package tsfo_pkg;
  typedef struct packed {
    logic high_ref;
    logic half_duty;
    logic early;
    logic invert;
    logic master;
    logic enable;
  } tsfo_ctrl_t;
  typedef struct packed {
    logic sdo;
    logic sdo_oe;
    logic bclk;
    logic bclk_oe;
    logic fs;
    logic fs_oe;
  } tsfo_link_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT, ST_DONE} tsfo_state_t;
endpackage
`default_nettype wire

//--- rtl/tsfo_pair_buf.sv
// small valid/ready buffer between the byte source and the slot shifter
`timescale 1ns/1ns
`default_nettype none
module tsfo_pair_buf
  import tsfo_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // fill side
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  // drain side
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin
    $error("buffer depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;

  wire full = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) && (wptr_reg[AW] != rptr_reg[AW]);
  wire empty = (wptr_reg == rptr_reg);
  wire push = wr_valid_in && !full;
  wire pop = rd_ready_in && !empty;

  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem_reg[rptr_reg[AW-1:0]];

  always_ff @(posedge mclk_in)
  begin
    if (push)
      mem_reg[wptr_reg[AW-1:0]] <= wr_data_in;
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else
    begin
      wptr_reg <= push ? wptr_reg + 1'b1 : wptr_reg;
      rptr_reg <= pop ? rptr_reg + 1'b1 : rptr_reg;
    end
  end
endmodule
`default_nettype wire

//--- rtl/tsfo_frame_out.sv
// tdm frame output: apb registers, bit clock and frame sync timing, slot shifter
`timescale 1ns/1ns
`default_nettype none
`include "tsfo_cfg.svh"
module tsfo_frame_out
  import tsfo_pkg::*;
#(
  parameter int SLOTS = `TSFO_MAX_SLOTS,
  parameter int SLOT_BITS = `TSFO_SLOT_BITS
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // slot data stream
  input wire logic [SLOT_BITS-1:0] byte_data_in,
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  // tdm link pins
  input wire logic port_bit_clock_in,
  output logic port_bit_clock_out,
  output logic port_bit_clock_oe_out,
  input wire logic port_frame_sync_in,
  output logic port_frame_sync_out,
  output logic port_frame_sync_oe_out,
  output logic port_serial_data_out,
  output logic port_serial_data_oe_out
);
  localparam int BW = $clog2(SLOT_BITS);
  localparam int FRAME_BITS = SLOTS * SLOT_BITS;
  localparam logic [3:0] MIN_HALF = 4'(`TSFO_BCLK_MIN_HALF_CYC);

  if (SLOTS < 1 || SLOTS > `TSFO_MAX_SLOTS || SLOT_BITS < 2 || SLOT_BITS > 16)
  begin
    $error("slot count or slot width out of range");
  end

  function automatic logic [5:0] reg_hit(input logic [11:0] addr);
    reg_hit[0] = (addr == `TSFO_OFF_CTRL);
    reg_hit[1] = (addr == `TSFO_OFF_FSW);
    reg_hit[2] = (addr == `TSFO_OFF_FLEN);
    reg_hit[3] = (addr == `TSFO_OFF_SLOT_LO);
    reg_hit[4] = (addr == `TSFO_OFF_SLOT_HI);
    reg_hit[5] = (addr == `TSFO_OFF_STATUS);
  endfunction

  tsfo_ctrl_t ctrl_reg;
  logic [10:0] fsw_reg;
  logic [15:0] flen_reg;
  logic [47:0] slot_en_reg;
  logic underrun_reg;
  logic rate_err_reg;
  logic [5:0] avail_reg;
  logic [31:0] prdata_reg;
  logic [31:0] ctrl_word;
  logic bclk_s1, bclk_s2, bclk_s3;
  logic fs_s1, fs_s2, fs_s3;
  logic [3:0] hp_cnt_reg;
  logic mbclk_reg;
  logic mfs_reg;
  logic [3:0] hcnt_reg;
  logic [15:0] mbit_reg;
  logic [15:0] fbc_reg;
  tsfo_state_t state_reg, state_next;
  logic seen_reg, seen_next;
  logic [5:0] slot_reg, slot_next;
  logic [BW-1:0] bit_reg, bit_next;
  logic [SLOT_BITS-1:0] shreg_reg, shreg_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic [SLOT_BITS-1:0] buf_data;
  logic buf_valid;
  tsfo_link_t link;

  // register access
  wire [5:0] hit = reg_hit(paddr_in);
  wire apb_wr = psel_in && penable_in && pwrite_in;
  wire apb_setup = psel_in && !penable_in;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && (hit == 6'h00);
  assign prdata_out = prdata_reg;

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`TSFO_CTRL_EN] = ctrl_reg.enable;
    ctrl_word[`TSFO_CTRL_MASTER] = ctrl_reg.master;
    ctrl_word[`TSFO_CTRL_INVERT] = ctrl_reg.invert;
    ctrl_word[`TSFO_CTRL_EARLY] = ctrl_reg.early;
    ctrl_word[`TSFO_CTRL_HALF_DUTY] = ctrl_reg.half_duty;
    ctrl_word[`TSFO_CTRL_HIGH_REF] = ctrl_reg.high_ref;
  end

  wire [31:0] status_word = 32'h0000_0000
    | (32'(underrun_reg) << `TSFO_ST_UNDERRUN)
    | (32'(rate_err_reg) << `TSFO_ST_RATE_ERR)
    | (32'(state_reg == ST_SHIFT) << `TSFO_ST_ACTIVE)
    | (32'(avail_reg) << `TSFO_ST_SLOTS_LSB);
  wire [31:0] rd_word =
    hit[0] ? ctrl_word :
    hit[1] ? {21'h000000, fsw_reg} :
    hit[2] ? {16'h0000, flen_reg} :
    hit[3] ? slot_en_reg[31:0] :
    hit[4] ? {16'h0000, slot_en_reg[47:32]} :
    hit[5] ? status_word : 32'h0000_0000;

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      prdata_reg <= 32'h0000_0000;
    else if (apb_setup)
      prdata_reg <= rd_word;
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_reg <= `TSFO_RST_CTRL;
      fsw_reg <= `TSFO_RST_FSW;
      flen_reg <= `TSFO_RST_FLEN;
      slot_en_reg <= `TSFO_RST_SLOT;
    end
    else if (apb_wr)
    begin
      if (hit[0])
      begin
        ctrl_reg.enable <= pwdata_in[`TSFO_CTRL_EN];
        ctrl_reg.master <= pwdata_in[`TSFO_CTRL_MASTER];
        ctrl_reg.invert <= pwdata_in[`TSFO_CTRL_INVERT];
        ctrl_reg.early <= pwdata_in[`TSFO_CTRL_EARLY];
        ctrl_reg.half_duty <= pwdata_in[`TSFO_CTRL_HALF_DUTY];
        ctrl_reg.high_ref <= pwdata_in[`TSFO_CTRL_HIGH_REF];
      end
      if (hit[1])
        fsw_reg <= pwdata_in[`TSFO_FSW_MSB:0];
      if (hit[2])
        flen_reg <= pwdata_in[`TSFO_FLEN_MSB:0];
      if (hit[3])
        slot_en_reg[31:0] <= pwdata_in;
      if (hit[4])
        slot_en_reg[47:32] <= pwdata_in[`TSFO_SLOT_HI_MSB:0];
    end
  end

  // link inputs, two flip-flops before use; the external master owns both in slave mode
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
      {fs_s1, fs_s2, fs_s3} <= 3'h0;
    end
    else
    begin
      {bclk_s1, bclk_s2, bclk_s3} <= {port_bit_clock_in, bclk_s1, bclk_s2};
      {fs_s1, fs_s2, fs_s3} <= {port_frame_sync_in, fs_s1, fs_s2};
    end
  end

  wire s_rise_pin = bclk_s2 && !bclk_s3;
  wire s_fall_pin = !bclk_s2 && bclk_s3;
  wire s_fs_rise = fs_s2 && !fs_s3;

  // master bit clock: toggles on every master clock, or at the finest rate the high reference limit allows in high reference mode
  wire run_m = ctrl_reg.enable && ctrl_reg.master;
  wire hr_m = run_m && ctrl_reg.high_ref;
  wire [3:0] half_lim = ctrl_reg.high_ref ? MIN_HALF : 4'h1;
  wire m_tog = run_m && (hcnt_reg + 4'h1 >= half_lim);
  wire m_rise = m_tog && !mbclk_reg;
  wire m_fall = m_tog && mbclk_reg;
  wire m_wrap = (mbit_reg >= flen_reg - 16'h0001);
  wire [15:0] mbit_next = m_wrap ? 16'h0000 : mbit_reg + 16'h0001;
  wire [15:0] fs_high = ctrl_reg.half_duty ? {1'b0, flen_reg[15:1]} :
    {5'h00, fsw_reg} + 16'h0001;

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hcnt_reg <= 4'h0;
      mbclk_reg <= 1'b0;
      mbit_reg <= 16'h0000;
      mfs_reg <= 1'b0;
    end
    else
    begin
      hcnt_reg <= (m_tog || !run_m) ? 4'h0 : hcnt_reg + 4'h1;
      mbclk_reg <= run_m ? (mbclk_reg ^ m_tog) : 1'b0;
      if (m_fall)
      begin
        mbit_reg <= mbit_next;
        mfs_reg <= (mbit_next < fs_high);
      end
    end
  end

  // slave bit clock rate check in high reference mode
  wire rate_bad = ctrl_reg.enable && !ctrl_reg.master && ctrl_reg.high_ref
    && (s_rise_pin || s_fall_pin) && (hp_cnt_reg + 4'h1 < MIN_HALF);

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      hp_cnt_reg <= 4'h0;
    else if (s_rise_pin || s_fall_pin)
      hp_cnt_reg <= 4'h0;
    else if (hp_cnt_reg != 4'hF)
      hp_cnt_reg <= hp_cnt_reg + 4'h1;
  end

  // internal edges: the invert control swaps which pin edge counts as rising
  wire irise = ctrl_reg.master ? m_rise : (ctrl_reg.invert ? s_fall_pin : s_rise_pin);
  wire ifall = ctrl_reg.master ? m_fall : (ctrl_reg.invert ? s_rise_pin : s_fall_pin);
  wire fs_rise_ev = ctrl_reg.enable && (ctrl_reg.master ? (m_fall && m_wrap) : s_fs_rise);
  wire launch_edge = ctrl_reg.early ? ifall : irise;
  wire first_launch = (state_reg == ST_WAIT) && seen_reg && launch_edge;
  wire shift_go = ctrl_reg.enable && !fs_rise_ev
    && (first_launch || (state_reg == ST_SHIFT && launch_edge));
  wire in_range = (slot_reg < 6'(SLOTS));
  wire slot_on = in_range && slot_en_reg[slot_reg];
  wire load = shift_go && slot_on && (bit_reg == '0);
  wire [SLOT_BITS-1:0] fresh = buf_valid ? buf_data : '0;

  tsfo_pair_buf #(
    .WIDTH(SLOT_BITS),
    .DEPTH(2)
  ) u_buf (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .wr_data_in(byte_data_in),
    .wr_valid_in(byte_valid_in),
    .wr_ready_out(byte_ready_out),
    .rd_data_out(buf_data),
    .rd_valid_out(buf_valid),
    .rd_ready_in(load)
  );

  always_comb
  begin
    state_next = state_reg;
    seen_next = seen_reg;
    slot_next = slot_reg;
    bit_next = bit_reg;
    shreg_next = shreg_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    if (!ctrl_reg.enable)
    begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
      sdo_next = 1'b0;
    end
    else if (fs_rise_ev)
    begin
      state_next = ST_WAIT;
      seen_next = 1'b0;
      slot_next = 6'h00;
      bit_next = '0;
      oe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_WAIT:
          if (irise)
            seen_next = 1'b1;
        ST_IDLE, ST_SHIFT, ST_DONE:
          state_next = state_reg;
      endcase
      if (shift_go)
      begin
        state_next = in_range ? ST_SHIFT : ST_DONE;
        oe_next = slot_on;
        if (!in_range || !slot_on)
          sdo_next = 1'b0;
        else if (bit_reg == '0)
          sdo_next = fresh[SLOT_BITS-1];
        else
          sdo_next = shreg_reg[SLOT_BITS-1];
        shreg_next = (bit_reg == '0) ? (fresh << 1) : (shreg_reg << 1);
        if (in_range && bit_reg == BW'(SLOT_BITS - 1))
        begin
          bit_next = '0;
          slot_next = slot_reg + 6'h01;
        end
        else if (in_range)
          bit_next = bit_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= ST_IDLE;
      seen_reg <= 1'b0;
      slot_reg <= 6'h00;
      bit_reg <= '0;
      shreg_reg <= '0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      seen_reg <= seen_next;
      slot_reg <= slot_next;
      bit_reg <= bit_next;
      shreg_reg <= shreg_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
    end
  end

  // frame length in bit clocks gives the usable slot count; the remainder stays unused
  wire [15:0] slots_seen = fbc_reg / 16'(SLOT_BITS);
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fbc_reg <= 16'h0000;
      avail_reg <= 6'h00;
    end
    else if (fs_rise_ev)
    begin
      fbc_reg <= 16'h0000;
      avail_reg <= (fbc_reg >= 16'(FRAME_BITS)) ? 6'(SLOTS) : slots_seen[5:0];
    end
    else if (irise && fbc_reg != 16'hFFFF)
      fbc_reg <= fbc_reg + 16'h0001;
  end

  // sticky status, write one to clear; a new event wins over the clear
  wire clr_st = apb_wr && hit[5];
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      underrun_reg <= 1'b0;
      rate_err_reg <= 1'b0;
    end
    else
    begin
      underrun_reg <= (load && !buf_valid)
        || (underrun_reg && !(clr_st && pwdata_in[`TSFO_ST_UNDERRUN]));
      rate_err_reg <= rate_bad
        || (rate_err_reg && !(clr_st && pwdata_in[`TSFO_ST_RATE_ERR]));
    end
  end

  always_comb
  begin
    link.sdo = sdo_reg;
    link.sdo_oe = oe_reg;
    link.bclk = mbclk_reg ^ ctrl_reg.invert;
    link.bclk_oe = run_m;
    link.fs = mfs_reg;
    link.fs_oe = run_m;
  end
  assign port_serial_data_out = link.sdo;
  assign port_serial_data_oe_out = link.sdo_oe;
  assign port_bit_clock_out = link.bclk;
  assign port_bit_clock_oe_out = link.bclk_oe;
  assign port_frame_sync_out = link.fs;
  assign port_frame_sync_oe_out = link.fs_oe;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_frame_open;
    fs_rise_ev ##1 (state_reg == ST_WAIT && !seen_reg && slot_reg == 6'h00);
  endsequence
  sequence s_fast_master;
    (ctrl_reg.enable && ctrl_reg.master && !ctrl_reg.high_ref)[*2];
  endsequence

  AST_FRAME_START: assert property (fs_rise_ev |-> s_frame_open)
    else $error("frame sync rise did not open a frame");
  AST_FIRST_DEFAULT: assert property ((state_reg == ST_WAIT && seen_reg && irise
    && !ctrl_reg.early && ctrl_reg.enable && !fs_rise_ev)
    |=> (state_reg == ST_SHIFT && slot_reg == 6'h00 && bit_reg == BW'(1)))
    else $error("default first bit not on second rise");
  AST_EARLY: assert property ((state_reg == ST_WAIT && seen_reg && ifall
    && ctrl_reg.early && ctrl_reg.enable && !fs_rise_ev) |=> state_reg == ST_SHIFT)
    else $error("early first bit not half a cycle earlier");
  AST_INV_EARLY: assert property ((first_launch && ctrl_reg.invert && ctrl_reg.early
    && !ctrl_reg.master) |-> s_rise_pin)
    else $error("invert plus early did not launch on a rising pin edge");
  AST_INV_ONLY: assert property ((first_launch && ctrl_reg.invert && !ctrl_reg.early
    && !ctrl_reg.master) |-> s_fall_pin)
    else $error("invert alone did not launch on a falling pin edge");
  AST_FS_WIDTH: assert property ((m_fall && run_m && !ctrl_reg.half_duty && m_wrap)
    |=> port_frame_sync_out)
    else $error("frame sync not raised at frame start");
  AST_MASTER_CLK: assert property (s_fast_master |-> mbclk_reg != $past(mbclk_reg))
    else $error("master bit clock not following the master clock");
  AST_RATE: assert property ((hr_m && $changed(mbclk_reg))
    |=> (!hr_m || $stable(mbclk_reg)))
    else $error("bit clock too fast in high reference mode");
  AST_SLOT_CAP: assert property (oe_reg |-> slot_reg <= 6'(SLOTS))
    else $error("data driven past the last slot");
  AST_SLOT_COUNT: assert property (fs_rise_ev |=> avail_reg <= 6'(SLOTS))
    else $error("usable slot count above the cap");
  AST_DRIVE: assert property ((shift_go && slot_on) |=> oe_reg)
    else $error("enabled slot not driven");
  AST_HIZ: assert property ((shift_go && !slot_on) |=> (!oe_reg && !port_serial_data_oe_out))
    else $error("disabled slot still driven");
  AST_BURST: assert property (($past(ctrl_reg.enable) && !$past(shift_go))
    |-> $stable(sdo_reg))
    else $error("data changed without a bit clock edge");
endmodule
`default_nettype wire

//--- verification/tsfo_tdm_host.sv
// tdm receiver model: drives bit clock and frame sync, samples the data line
`timescale 1ns/1ns
`default_nettype none
module tsfo_tdm_host
(
  // clock and mode
  input wire logic mclk_in,
  input wire logic invert_in,
  // link pins
  output logic bclk_out,
  output logic fs_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  logic line_q[$];
  logic oe_q[$];
  logic line_level;

  // a released line floats up through its pull-up
  assign line_level = sdo_oe_in ? sdo_in : 1'b1;

  initial
  begin
    bclk_out = 1'b0;
    fs_out = 1'b0;
  end

  // one frame: clock idles so the first toggle is an inner rising edge,
  // then a burst of toggles and the clock stands still again
  task automatic run_frame(input int toggles);
    line_q.delete();
    oe_q.delete();
    bclk_out <= invert_in;
    repeat (6) @(posedge mclk_in);
    fs_out <= 1'b1;
    for (int t = 1; t <= toggles; t++)
    begin
      repeat (6) @(posedge mclk_in);
      line_q.push_back(line_level);
      oe_q.push_back(sdo_oe_in);
      bclk_out <= ~bclk_out;
      if (t == 2)
        fs_out <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- verification/test_tdm_serial_frame_output.sv
// self-checking bench for the tdm frame output
`timescale 1ns/1ns
`default_nettype none
`include "tsfo_cfg.svh"
module test_tdm_serial_frame_output;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [7:0] byte_data_in = 8'h00;
  logic byte_valid_in = 1'b0;
  logic host_invert = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, byte_ready_out, port_bit_clock_in, port_bit_clock_out;
  logic port_bit_clock_oe_out, port_frame_sync_in, port_frame_sync_out;
  logic port_frame_sync_oe_out, port_serial_data_out, port_serial_data_oe_out;
  logic [31:0] r;
  logic e;
  int hi, per;
  int n_mismatch = 0;
  int check_count = 0;

  always #20 mclk_in = ~mclk_in;

  tsfo_frame_out uut (
    .mclk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .byte_data_in, .byte_valid_in,
    .byte_ready_out, .port_bit_clock_in, .port_bit_clock_out, .port_bit_clock_oe_out,
    .port_frame_sync_in, .port_frame_sync_out, .port_frame_sync_oe_out,
    .port_serial_data_out, .port_serial_data_oe_out
  );

  tsfo_tdm_host host (
    .mclk_in, .invert_in(host_invert), .bclk_out(port_bit_clock_in),
    .fs_out(port_frame_sync_in), .sdo_in(port_serial_data_out),
    .sdo_oe_in(port_serial_data_oe_out)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("register %h", a), r, exp);
  endtask

  task automatic push(input logic [7:0] d);
    @(posedge mclk_in);
    byte_data_in <= d;
    byte_valid_in <= 1'b1;
    do @(posedge mclk_in); while (byte_ready_out !== 1'b1);
    byte_valid_in <= 1'b0;
  endtask

  // slots 0 and 2 enabled, slot 1 released; bit b sits at toggle 4 - early + 2b
  task automatic frame_chk(input int early, input logic [7:0] d0, input logic [7:0] d2);
    logic [7:0] ln, oe;
    host.run_frame(52);
    for (int s = 0; s < 3; s++)
    begin
      for (int k = 0; k < 8; k++)
      begin
        ln[7 - k] = host.line_q[3 - early + 2 * (s * 8 + k)];
        oe[7 - k] = host.oe_q[3 - early + 2 * (s * 8 + k)];
      end
      chk("slot data", ln, (s == 0) ? d0 : (s == 1) ? 8'hFF : d2);
      chk("slot drive", oe, (s == 1) ? 8'h00 : 8'hFF);
    end
  endtask

  task automatic toggles(input int exp);
    int c;
    logic p;
    c = 0;
    // start one edge late: the control write lands on the edge the caller returns on
    @(posedge mclk_in);
    p = port_bit_clock_out;
    repeat (20)
    begin
      @(posedge mclk_in);
      if (port_bit_clock_out !== p)
        c++;
      p = port_bit_clock_out;
    end
    chk("bit clock toggles", c, exp);
  endtask

  // frame sync high time and period in system clocks
  task automatic meas;
    hi = 0;
    while (port_frame_sync_out !== 1'b0) @(posedge mclk_in);
    while (port_frame_sync_out !== 1'b1) @(posedge mclk_in);
    while (port_frame_sync_out === 1'b1)
    begin
      hi++;
      @(posedge mclk_in);
    end
    per = hi;
    while (port_frame_sync_out !== 1'b1)
    begin
      per++;
      @(posedge mclk_in);
    end
  endtask

  initial
  begin
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rdc(`TSFO_OFF_CTRL, 32'h0000_0000);
    rdc(`TSFO_OFF_FSW, 32'h0000_0000);
    rdc(`TSFO_OFF_FLEN, 32'h0000_0190);
    rdc(`TSFO_OFF_SLOT_LO, 32'h0000_0000);
    rdc(`TSFO_OFF_SLOT_HI, 32'h0000_0000);
    rdc(`TSFO_OFF_STATUS, 32'h0000_0000);
    apb(1'b1, `TSFO_OFF_FSW, 32'hFFFF_FFFF);
    rdc(`TSFO_OFF_FSW, 32'h0000_07FF);
    apb(1'b1, `TSFO_OFF_SLOT_HI, 32'hFFFF_FFFF);
    rdc(`TSFO_OFF_SLOT_HI, 32'h0000_FFFF);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", r, 32'h0000_0000);
    $display("test registers done");
    apb(1'b1, `TSFO_OFF_SLOT_LO, 32'h0000_0005);
    for (int f = 0; f < 4; f++)
    begin
      host_invert <= f[0];
      apb(1'b1, `TSFO_OFF_CTRL, {28'h000_0000, f[1], f[0], 1'b0, 1'b1});
      push(8'hA5 ^ f[7:0]);
      push(8'h3C + f[7:0]);
      @(posedge mclk_in);
      chk("buffer full", byte_ready_out, 1'b0);
      frame_chk(f[1], 8'hA5 ^ f[7:0], 8'h3C + f[7:0]);
    end
    $display("test slave formats done");
    frame_chk(1, 8'h00, 8'h00);
    apb(1'b0, `TSFO_OFF_STATUS, 32'h0000_0000);
    chk("underrun flag", r[0], 1'b1);
    apb(1'b1, `TSFO_OFF_STATUS, 32'h0000_0001);
    apb(1'b0, `TSFO_OFF_STATUS, 32'h0000_0000);
    chk("underrun cleared", r[0], 1'b0);
    $display("test underrun done");
    apb(1'b1, `TSFO_OFF_FLEN, 32'h0000_0020);
    apb(1'b1, `TSFO_OFF_FSW, 32'h0000_0003);
    apb(1'b1, `TSFO_OFF_CTRL, 32'h0000_0003);
    toggles(20);
    chk("clock drive", port_bit_clock_oe_out, 1'b1);
    chk("sync drive", port_frame_sync_oe_out, 1'b1);
    meas();
    chk("sync high", hi, 8);
    chk("frame period", per, 64);
    apb(1'b1, `TSFO_OFF_CTRL, 32'h0000_0013);
    meas();
    chk("half duty high", hi, 32);
    apb(1'b1, `TSFO_OFF_CTRL, 32'h0000_0023);
    toggles(10);
    meas();
    chk("slow sync high", hi, 16);
    chk("slow frame period", per, 128);
    $display("test master done");
    results();
  end

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    $display("Error watchdog expected finish seen hang");
    results();
  end
endmodule
`default_nettype wire
